// ---- rtl/dac_mu_delay_config_map.vh ----
`ifndef DAC_MU_DELAY_CONFIG_MAP_VH
`define DAC_MU_DELAY_CONFIG_MAP_VH
// Behaviour
// RULE_01: Bias top bit one powers converter down
// RULE_02: Mirror select: bypass, narrow, medium, wide
// RULE_03: Decoder: normal, return-to-zero, mix; 11 invalid
// RULE_04: Decoder mode resets to normal
// RULE_05: Nine-bit delay, LSB low bit 7
// RULE_06: Search starts from programmed delay value
// RULE_07: Manual mode applies written delay directly
// RULE_08: Tracking reads return sampled controller delay
// RULE_09: Software keeps delay at or below 431
// RULE_10: Software should start search near 216
// RULE_11: Direction: down, up, both; 11 invalid
// RULE_12: Target phase above 16 never locks
// RULE_13: Lock needs measured slope matching polarity
// RULE_14: Software should use positive slope, phase 14
// RULE_15: Snapshot bit rising edge captures delay, phase
// RULE_16: Enable bit: zero manual, one automatic
// RULE_17: Mode: search-track, track, search; 11 invalid
// RULE_18: Slope bit: zero negative, one positive
// RULE_19: Reserved bits read zero, writes ignored

// ****************************************
// Register offsets
// ****************************************
`define ADDR_DELAY_CTRL      13'h0033
`define ADDR_DAC_BIAS        13'h0036
`define ADDR_DECODER_SELECT  13'h0038
`define ADDR_DELAY_LOW       13'h0039
`define ADDR_DELAY_HIGH      13'h003a

// ****************************************
// Field positions
// ****************************************
`define BIT_POWER_DOWN       7
`define BIT_SLOPE            6
`define BIT_MODE_HI          5
`define BIT_MODE_LO          4
`define BIT_SNAPSHOT         3
`define BIT_AUTO_EN          0
`define BIT_DELAY_LSB        7
`define BIT_DIR_HI           6
`define BIT_DIR_LO           5

// ****************************************
// Reset values and limits
// ****************************************
`define RST_BYTE             8'h00
`define RST_CODE2            2'b00
`define RST_DELAY            9'h000
`define RST_PHASE            5'h00
`define CODE_INVALID         2'b11
`define PHASE_MAX            5'h10

// ****************************************
// Serial frame timing
// ****************************************
`define FRAME_INSTR_BITS     5'd16
`define FRAME_TOTAL_BITS     5'd24
`endif

// ---- rtl/pin_sync.v ----
`timescale 1ns/100ps
module pin_sync #(
  parameter W = 3
) (
  input  wire         clk_sys_i,
  input  wire         nrst_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // pin_sync

// ---- rtl/spi_frame.v ----
`timescale 1ns/100ps
`include "dac_mu_delay_config_map.vh"
module spi_frame (
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  input  wire        sclk_i,
  input  wire        csb_i,
  input  wire        sdi_i,
  input  wire [7:0]  rd_data_i,
  output wire [12:0] addr_o,
  output wire [7:0]  wr_data_o,
  output wire        wr_stb_o,
  output wire        sdo_o,
  output wire        sdo_oe_n_o
);
  // ****************************************
  // Serial frame engine
  // ****************************************
  reg        sclk_prev_q;
  reg [4:0]  bit_cnt_q;
  reg [15:0] shift_q;
  reg        rnw_q;
  reg [12:0] addr_q;
  reg [7:0]  wr_data_q;
  reg        wr_stb_q;
  reg        load_q;
  reg [7:0]  out_q;
  reg        sdo_q;
  reg        oe_n_q;

  wire rise = sclk_i & ~sclk_prev_q;
  wire fall = ~sclk_i & sclk_prev_q;

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q   <= 5'd0;
      shift_q     <= 16'h0000;
      rnw_q       <= 1'b0;
      addr_q      <= 13'h0000;
      wr_data_q   <= 8'h00;
      wr_stb_q    <= 1'b0;
      load_q      <= 1'b0;
      out_q       <= 8'h00;
      sdo_q       <= 1'b0;
      oe_n_q      <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_i;
      wr_stb_q    <= 1'b0;
      if (csb_i) begin
        bit_cnt_q <= 5'd0;
        load_q    <= 1'b0;
        oe_n_q    <= 1'b1;
      end else begin
        if (rise && bit_cnt_q < `FRAME_TOTAL_BITS) begin
          shift_q   <= {shift_q[14:0], sdi_i};
          bit_cnt_q <= bit_cnt_q + 5'd1;
          if (bit_cnt_q == `FRAME_INSTR_BITS - 5'd1) begin
            rnw_q  <= shift_q[14];
            addr_q <= {shift_q[11:0], sdi_i};
            load_q <= shift_q[14];
          end
          // Single byte per frame; later clocks ignored
          if (bit_cnt_q == `FRAME_TOTAL_BITS - 5'd1) begin
            wr_data_q <= {shift_q[6:0], sdi_i};
            wr_stb_q  <= ~rnw_q;
          end
        end
        if (fall && rnw_q && bit_cnt_q >= `FRAME_INSTR_BITS) begin
          if (bit_cnt_q == `FRAME_TOTAL_BITS) begin
            oe_n_q <= 1'b1;
          end else if (load_q) begin
            oe_n_q <= 1'b0;
            load_q <= 1'b0;
            sdo_q  <= rd_data_i[7];
            out_q  <= {rd_data_i[6:0], 1'b0};
          end else begin
            sdo_q <= out_q[7];
            out_q <= {out_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  assign addr_o     = addr_q;
  assign wr_data_o  = wr_data_q;
  assign wr_stb_o   = wr_stb_q;
  assign sdo_o      = sdo_q;
  assign sdo_oe_n_o = oe_n_q;
endmodule // spi_frame

// ---- rtl/dac_mu_delay_config_regs.v ----
`timescale 1ns/100ps
`include "dac_mu_delay_config_map.vh"
module dac_mu_delay_config_regs (
  input  wire       clk_sys_i,
  input  wire       nrst_i,
  input  wire       spi_sclk_i,
  input  wire       spi_csb_i,
  input  wire       spi_sdi_i,
  output reg        spi_sdo_o,
  output reg        spi_sdo_oe_n_o,
  input  wire [8:0] ctrl_delay_i,
  input  wire [4:0] ctrl_phase_i,
  input  wire       ctrl_phase_match_i,
  input  wire       ctrl_slope_pos_i,
  output reg        converter_power_down_o,
  output reg [1:0]  mirror_rolloff_select_o,
  output reg        mirror_bypass_o,
  output reg        decoder_rz_o,
  output reg        decoder_mix_o,
  output reg [8:0]  delay_tap_value_o,
  output reg        delay_manual_apply_o,
  output reg        search_down_o,
  output reg        search_up_o,
  output reg [4:0]  target_phase_code_o,
  output reg        target_phase_valid_o,
  output reg        slope_positive_o,
  output reg        auto_delay_enable_o,
  output reg        search_enable_o,
  output reg        track_enable_o,
  output reg        lock_accept_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function legal2;
    input [1:0] code;
    begin
      legal2 = (code != `CODE_INVALID);
    end
  endfunction

  // ****************************************
  // Pin synchronisation and serial port
  // ****************************************
  wire [2:0]  pins_s;
  wire [12:0] addr;
  wire [7:0]  wr_data;
  wire        wr_stb;
  wire        sdo;
  wire        sdo_oe_n;
  reg  [7:0]  rd_data;

  pin_sync #(.W(3)) u_sync (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .async_i   ({spi_sclk_i, spi_csb_i, spi_sdi_i}),
    .sync_o    (pins_s)
  );

  spi_frame u_spi (
    .clk_sys_i  (clk_sys_i),
    .nrst_i     (nrst_i),
    .sclk_i     (pins_s[2]),
    .csb_i      (pins_s[1]),
    .sdi_i      (pins_s[0]),
    .rd_data_i  (rd_data),
    .addr_o     (addr),
    .wr_data_o  (wr_data),
    .wr_stb_o   (wr_stb),
    .sdo_o      (sdo),
    .sdo_oe_n_o (sdo_oe_n)
  );

  // ****************************************
  // Register storage
  // ****************************************
  reg       power_down_q;
  reg [1:0] mirror_sel_q;
  reg [1:0] decoder_q;
  reg [8:0] delay_q;
  reg [1:0] dir_q;
  reg [4:0] phase_q;
  reg       slope_q;
  reg [1:0] mode_q;
  reg       snap_bit_q;
  reg       auto_en_q;
  reg [8:0] snap_delay_q;
  reg [4:0] snap_phase_q;

  wire wr_ctrl = wr_stb && (addr == `ADDR_DELAY_CTRL);
  wire wr_bias = wr_stb && (addr == `ADDR_DAC_BIAS);
  wire wr_dec  = wr_stb && (addr == `ADDR_DECODER_SELECT);
  wire wr_low  = wr_stb && (addr == `ADDR_DELAY_LOW);
  wire wr_high = wr_stb && (addr == `ADDR_DELAY_HIGH);
  wire snap_rise = wr_ctrl && wr_data[`BIT_SNAPSHOT] && !snap_bit_q;
  wire tracking  = auto_en_q;

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_down_q <= 1'b0;
      mirror_sel_q <= `RST_CODE2;
      decoder_q    <= `RST_CODE2; // [RULE_04]
      delay_q      <= `RST_DELAY;
      dir_q        <= `RST_CODE2;
      phase_q      <= `RST_PHASE;
      slope_q      <= 1'b0;
      mode_q       <= `RST_CODE2;
      snap_bit_q   <= 1'b0;
      auto_en_q    <= 1'b0;
      snap_delay_q <= `RST_DELAY;
      snap_phase_q <= `RST_PHASE;
    end else begin
      if (wr_bias) begin
        power_down_q <= wr_data[`BIT_POWER_DOWN]; // [RULE_01]
        mirror_sel_q <= wr_data[1:0]; // [RULE_02]
      end
      // Invalid codes are dropped so the output never sees them
      if (wr_dec && legal2(wr_data[1:0])) begin
        decoder_q <= wr_data[1:0]; // [RULE_03]
      end
      if (wr_low) begin
        delay_q[0] <= wr_data[`BIT_DELAY_LSB]; // [RULE_05] [RULE_07]
        phase_q    <= wr_data[4:0];
        if (legal2(wr_data[`BIT_DIR_HI:`BIT_DIR_LO])) begin
          dir_q <= wr_data[`BIT_DIR_HI:`BIT_DIR_LO]; // [RULE_11]
        end
      end
      if (wr_high) begin
        delay_q[8:1] <= wr_data; // [RULE_05] [RULE_07]
      end
      if (wr_ctrl) begin
        slope_q    <= wr_data[`BIT_SLOPE]; // [RULE_18]
        snap_bit_q <= wr_data[`BIT_SNAPSHOT];
        auto_en_q  <= wr_data[`BIT_AUTO_EN]; // [RULE_16]
        if (legal2(wr_data[`BIT_MODE_HI:`BIT_MODE_LO])) begin
          mode_q <= wr_data[`BIT_MODE_HI:`BIT_MODE_LO]; // [RULE_17]
        end
      end
      if (snap_rise) begin
        snap_delay_q <= ctrl_delay_i; // [RULE_15]
        snap_phase_q <= ctrl_phase_i; // [RULE_15]
      end
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  always @* begin
    rd_data = `RST_BYTE; // [RULE_19]
    case (addr)
      `ADDR_DELAY_CTRL: begin
        rd_data = {1'b0, slope_q, mode_q, snap_bit_q, 2'b00, auto_en_q};
      end
      `ADDR_DAC_BIAS: begin
        rd_data = {power_down_q, 5'b00000, mirror_sel_q}; // [RULE_19]
      end
      `ADDR_DECODER_SELECT: begin
        rd_data = {6'b000000, decoder_q};
      end
      `ADDR_DELAY_LOW: begin
        if (tracking) begin
          rd_data = {snap_delay_q[0], dir_q, snap_phase_q}; // [RULE_08]
        end else begin
          rd_data = {delay_q[0], dir_q, phase_q};
        end
      end
      `ADDR_DELAY_HIGH: begin
        rd_data = tracking ? snap_delay_q[8:1] : delay_q[8:1]; // [RULE_08]
      end
      default: begin
        rd_data = `RST_BYTE;
      end
    endcase
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spi_sdo_o               <= 1'b0;
      spi_sdo_oe_n_o          <= 1'b1;
      converter_power_down_o  <= 1'b0;
      mirror_rolloff_select_o <= `RST_CODE2;
      mirror_bypass_o         <= 1'b1;
      decoder_rz_o            <= 1'b0;
      decoder_mix_o           <= 1'b0;
      delay_tap_value_o       <= `RST_DELAY;
      delay_manual_apply_o    <= 1'b1;
      search_down_o           <= 1'b1;
      search_up_o             <= 1'b0;
      target_phase_code_o     <= `RST_PHASE;
      target_phase_valid_o    <= 1'b1;
      slope_positive_o        <= 1'b0;
      auto_delay_enable_o     <= 1'b0;
      search_enable_o         <= 1'b1;
      track_enable_o          <= 1'b1;
      lock_accept_o           <= 1'b0;
    end else begin
      spi_sdo_o               <= sdo;
      spi_sdo_oe_n_o          <= sdo_oe_n;
      converter_power_down_o  <= power_down_q; // [RULE_01]
      mirror_rolloff_select_o <= mirror_sel_q; // [RULE_02]
      mirror_bypass_o         <= (mirror_sel_q == 2'b00); // [RULE_02]
      decoder_rz_o            <= (decoder_q == 2'b01); // [RULE_03]
      decoder_mix_o           <= (decoder_q == 2'b10); // [RULE_03]
      // Same value is the manual setting and the search start point
      delay_tap_value_o       <= delay_q; // [RULE_06] [RULE_07]
      delay_manual_apply_o    <= ~auto_en_q; // [RULE_07] [RULE_16]
      search_down_o           <= (dir_q != 2'b01); // [RULE_11]
      search_up_o             <= (dir_q != 2'b00); // [RULE_11]
      target_phase_code_o     <= phase_q;
      target_phase_valid_o    <= (phase_q <= `PHASE_MAX); // [RULE_12]
      slope_positive_o        <= slope_q; // [RULE_18]
      auto_delay_enable_o     <= auto_en_q; // [RULE_16]
      search_enable_o         <= (mode_q != 2'b01); // [RULE_17]
      track_enable_o          <= (mode_q != 2'b10); // [RULE_17]
      // Out-of-range phase blocks lock until a phase of 16 or less is written
      lock_accept_o           <= auto_en_q && ctrl_phase_match_i && (phase_q <= `PHASE_MAX) &&
                                 (ctrl_slope_pos_i == slope_q); // [RULE_12] [RULE_13]
    end
  end
endmodule // dac_mu_delay_config_regs

// ---- test/dac_mu_delay_config_checker.sv ----
`timescale 1ns/100ps
module dac_mu_delay_config_checker (
  input logic       clk_sys_i,
  input logic       nrst_i,
  input logic       ctrl_phase_match_i,
  input logic       ctrl_slope_pos_i,
  input logic [1:0] mirror_rolloff_select_o,
  input logic       mirror_bypass_o,
  input logic       decoder_rz_o,
  input logic       decoder_mix_o,
  input logic       delay_manual_apply_o,
  input logic       search_down_o,
  input logic       search_up_o,
  input logic [4:0] target_phase_code_o,
  input logic       target_phase_valid_o,
  input logic       slope_positive_o,
  input logic       auto_delay_enable_o,
  input logic       search_enable_o,
  input logic       track_enable_o,
  input logic       lock_accept_o
);
  // ****************************************
  // Output decode relations
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  bypass_decode_a: assert property (mirror_bypass_o == (mirror_rolloff_select_o == 2'b00))
    else $error("mirror bypass disagrees with select");
  decoder_exclusive_a: assert property (!(decoder_rz_o && decoder_mix_o))
    else $error("decoder rz and mix both set");
  manual_mode_a: assert property (delay_manual_apply_o == !auto_delay_enable_o)
    else $error("manual apply not inverse of enable");
  search_dir_a: assert property (search_down_o || search_up_o)
    else $error("no search direction selected");
  phase_valid_a: assert property (target_phase_valid_o == (target_phase_code_o <= 5'h10))
    else $error("phase valid flag wrong");
  mode_decode_a: assert property (search_enable_o || track_enable_o)
    else $error("neither search nor track enabled");
  // ****************************************
  // Lock acceptance
  // ****************************************
  // Lock and the config outputs share one register stage, so compare on the same edge
  lock_match_a: assert property (!ctrl_phase_match_i |=> !lock_accept_o)
    else $error("lock without phase match");
  lock_slope_a: assert property ((slope_positive_o != $past(ctrl_slope_pos_i)) |-> !lock_accept_o)
    else $error("lock with wrong slope");
  lock_phase_a: assert property (!target_phase_valid_o |-> !lock_accept_o)
    else $error("lock with phase above limit");
  lock_enable_a: assert property (!auto_delay_enable_o |-> !lock_accept_o)
    else $error("lock in manual mode");
endmodule // dac_mu_delay_config_checker

bind dac_mu_delay_config_regs dac_mu_delay_config_checker dac_mu_delay_config_checker_i (
  .clk_sys_i, .nrst_i, .ctrl_phase_match_i, .ctrl_slope_pos_i, .mirror_rolloff_select_o, .mirror_bypass_o,
  .decoder_rz_o, .decoder_mix_o, .delay_manual_apply_o, .search_down_o, .search_up_o, .target_phase_code_o,
  .target_phase_valid_o, .slope_positive_o, .auto_delay_enable_o, .search_enable_o, .track_enable_o,
  .lock_accept_o
);

// ---- test/tb.sv ----
`timescale 1ns/100ps
module tb;
  logic clk_sys_i = 0, nrst_i = 0, sclk = 0, csb = 1, sdi = 0, ctrl_match = 0, ctrl_slope = 0;
  logic [8:0] ctrl_delay = 0;
  logic [4:0] ctrl_phase = 0;
  wire  sdo, sdo_oe_n, pd, byp, rz, mix, man, sdn, sup, pval, slp, aen, sen, ten, lock;
  wire  [1:0] mirror_rolloff_select;
  wire  [8:0] dly;
  wire  [4:0] phz;
  integer fail_count = 0, tests_run = 0, cyc = 0, k;
  logic [7:0] v;
  logic [1:0] e;

  always #2.5 clk_sys_i = ~clk_sys_i;

  dac_mu_delay_config_regs dac_mu_delay_config_regs_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .spi_sclk_i(sclk), .spi_csb_i(csb), .spi_sdi_i(sdi),
    .spi_sdo_o(sdo), .spi_sdo_oe_n_o(sdo_oe_n), .ctrl_delay_i(ctrl_delay), .ctrl_phase_i(ctrl_phase),
    .ctrl_phase_match_i(ctrl_match), .ctrl_slope_pos_i(ctrl_slope), .converter_power_down_o(pd),
    .mirror_rolloff_select_o(mirror_rolloff_select), .mirror_bypass_o(byp), .decoder_rz_o(rz), .decoder_mix_o(mix),
    .delay_tap_value_o(dly), .delay_manual_apply_o(man), .search_down_o(sdn), .search_up_o(sup),
    .target_phase_code_o(phz), .target_phase_valid_o(pval), .slope_positive_o(slp),
    .auto_delay_enable_o(aen), .search_enable_o(sen), .track_enable_o(ten), .lock_accept_o(lock));

  // ****************************************
  // Serial access and compare tasks
  // ****************************************
  task automatic wait_clk(input integer n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  // Half period of 6 clocks keeps well clear of the synchroniser lag
  task automatic xfer(input [15:0] ins, input [7:0] wd, output [7:0] rd);
    logic [23:0] f;
    integer i;
    f = {ins, wd};
    rd = 8'h00;
    csb = 0;
    for (i = 0; i < 24; i++) begin
      sdi = f[23-i];
      wait_clk(6);
      sclk = 1;
      wait_clk(6);
      if (i >= 16) rd = {rd[6:0], sdo};
      sclk = 0;
    end
    wait_clk(6);
    csb = 1;
    wait_clk(10);
  endtask

  task automatic chk(input string n, input [8:0] exp, input [8:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr(input [12:0] a, input [7:0] d);
    xfer({3'b000, a}, d, v);
  endtask

  task automatic rc(input [12:0] a, input [7:0] exp);
    xfer({3'b100, a}, 8'h00, v);
    chk("readback", {1'b0, exp}, {1'b0, v});
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Roughly 38 frames of about 300 clocks each
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      final_report;
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    wait_clk(10);
    nrst_i = 1;
    wait_clk(5);
    chk("power_down", 0, pd);
    chk("decoder", 0, {mix, rz});
    rc(13'h0038, 8'h00);
    wr(13'h0036, 8'hff);
    chk("power_down", 1, pd);
    rc(13'h0036, 8'h83);
    for (k = 0; k < 4; k++) begin
      wr(13'h0036, k[7:0]);
      chk("mirror_sel", k[1:0], mirror_rolloff_select);
      chk("mirror_bypass", k == 0, byp);
    end
    chk("power_down", 0, pd);
    for (k = 0; k < 4; k++) begin
      wr(13'h0038, k[7:0]);
      e = (k == 3) ? 2'b10 : k[1:0];
      chk("decoder", e, {mix, rz});
      rc(13'h0038, {6'h00, e});
    end
    wr(13'h003a, 8'h6c);
    chk("delay_value", 9'h0d8, dly);
    for (k = 0; k < 4; k++) begin
      wr(13'h0039, {1'b1, k[1:0], 5'h10});
      e = (k == 3) ? 2'b10 : k[1:0];
      chk("direction", {e != 2'b01, e != 2'b00}, {sdn, sup});
    end
    wr(13'h003a, 8'hd7);
    chk("delay_value", 9'h1af, dly);
    chk("manual_apply", 1, man);
    rc(13'h003a, 8'hd7);
    rc(13'h0039, 8'hd0);
    chk("phase_valid", 1, pval);
    wr(13'h0039, 8'hd1);
    chk("phase_valid", 0, pval);
    ctrl_match = 1;
    ctrl_slope = 1;
    wr(13'h0033, 8'h41);
    chk("lock", 0, lock);
    wr(13'h0039, 8'hce);
    chk("lock", 1, lock);
    chk("phase_code", 9'h00e, {4'h0, phz});
    ctrl_slope = 0;
    wait_clk(3);
    chk("lock", 0, lock);
    ctrl_slope = 1;
    ctrl_match = 0;
    wait_clk(3);
    chk("lock", 0, lock);
    for (k = 0; k < 4; k++) begin
      wr(13'h0033, {2'b01, k[1:0], 4'h1});
      e = (k == 3) ? 2'b10 : k[1:0];
      chk("mode", {e != 2'b01, e != 2'b10}, {sen, ten});
    end
    chk("auto_enable", 1, aen);
    chk("slope", 1, slp);
    chk("manual_apply", 0, man);
    // Snapshot only on a rising write of the trigger bit
    ctrl_delay = 9'h0ab;
    ctrl_phase = 5'h0c;
    wr(13'h0033, 8'h49);
    rc(13'h003a, 8'h55);
    rc(13'h0039, 8'hcc);
    ctrl_delay = 9'h000;
    wr(13'h0033, 8'h49);
    rc(13'h003a, 8'h55);
    chk("delay_value", 9'h1af, dly);
    wr(13'h0033, 8'h00);
    rc(13'h003a, 8'hd7);
    rc(13'h0100, 8'h00);
    chk("sdo_oe_n", 1, sdo_oe_n);
    final_report;
  end
endmodule // tb
